// ==== core/brrp_pkg.sv ====
// Package with the shared constants of the buffer memory random port.
package brrp_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int CMD_SEL_W = 3;
  localparam int DEPTH = 8192;
  localparam int BYTE_W = 8;
  localparam int CMD_WR_W = 12;
  localparam int CMD_RD_W = 13;
  localparam logic [2:0] CMD_START1 = 3'h0;
  localparam logic [2:0] CMD_END1 = 3'h1;
  localparam logic [2:0] CMD_START2 = 3'h2;
  localparam logic [2:0] CMD_END2 = 3'h3;
  localparam logic [2:0] CMD_FLOW = 3'h4;
  localparam logic [2:0] CMD_FLAGS = 3'h5;
  localparam logic [12:0] RST_START1 = 13'h0000;
  localparam logic [12:0] RST_END1 = 13'h0FFF;
  localparam logic [12:0] RST_START2 = 13'h1000;
  localparam logic [12:0] RST_END2 = 13'h1FFF;
  localparam logic [12:0] RST_FLOW = 13'h0000;
  localparam int HOST_HOLD_CYC = 2;
  typedef enum logic [1:0] {BRRP_IDLE, BRRP_DRIVE, BRRP_HOLD} brrp_host_e;
endpackage : brrp_pkg

// ==== core/brrp_if.sv ====
// Interface joining the host and the buffer memory random port.
`timescale 1ns/100ps
interface brrp_if;
  logic port_select_n;
  logic cmd_select_n;
  logic read_write;
  logic output_enable_n;
  logic low_byte_enable_n;
  logic high_byte_enable_n;
  logic [12:0] addr;
  logic [15:0] host_data;
  logic [15:0] host_data_oe;
  logic [15:0] dev_data;
  logic [15:0] dev_data_oe;
  logic [15:0] data_bus;
  genvar i;
  for (i = 0; i < 16; i++) begin : g_bus
    assign data_bus[i] = dev_data_oe[i] ? dev_data[i] : (host_data_oe[i] ? host_data[i] : 1'b1);
  end
  modport device (input port_select_n, cmd_select_n, read_write, output_enable_n, low_byte_enable_n,
    high_byte_enable_n, addr, data_bus, output dev_data, dev_data_oe);
  modport host (output port_select_n, cmd_select_n, read_write, output_enable_n, low_byte_enable_n,
    high_byte_enable_n, addr, host_data, host_data_oe, input data_bus);
endinterface : brrp_if

// ==== core/brrp_seq_flags.sv ====
// Sequential pointer and end-of-buffer flag logic on the sequential clock.
`timescale 1ns/100ps
module brrp_seq_flags (
  input wire logic clock,
  input wire logic rstn,
  input wire logic seq_port_select_n,
  input wire logic pointer_advance_enable_n,
  input wire logic seq_read_write,
  input wire logic seq_output_enable_n,
  input wire logic [12:0] end_one,
  input wire logic [12:0] end_two,
  input wire logic clear_one,
  input wire logic clear_two,
  output logic [12:0] pointer,
  output logic buffer_one_end_flag_n,
  output logic buffer_two_end_flag_n,
  output logic retention,
  output logic read_active
);
  logic [12:0] next_pointer;
  assign next_pointer = pointer + 13'h0001;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pointer <= 13'h0000;
    end else if (!pointer_advance_enable_n) begin
      pointer <= next_pointer;
    end
  end
  // Flags drop when the advanced pointer meets the end address; a set wins over a clear.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      buffer_one_end_flag_n <= 1'b1;
      buffer_two_end_flag_n <= 1'b1;
    end else begin
      if (!pointer_advance_enable_n && next_pointer == end_one) begin
        buffer_one_end_flag_n <= 1'b0;
      end else if (clear_one) begin
        buffer_one_end_flag_n <= 1'b1;
      end
      if (!pointer_advance_enable_n && next_pointer == end_two) begin
        buffer_two_end_flag_n <= 1'b0;
      end else if (clear_two) begin
        buffer_two_end_flag_n <= 1'b1;
      end
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      retention <= 1'b1;
      read_active <= 1'b0;
    end else begin
      retention <= seq_port_select_n;
      read_active <= !seq_port_select_n && seq_read_write && !seq_output_enable_n;
    end
  end
endmodule : brrp_seq_flags

// ==== core/brrp_device.sv ====
// Device end: memory array, command registers and random port pin decode.
// Overview of operation
// - array read drives only enabled bytes.
// - array write stores only enabled bytes.
// - both selects high floats, powers down.
// - output enable high floats, stays powered.
// - both byte enables high, no transfer.
// - command write takes low data lines.
// - command read drives lines zero to twelve.
// - command accesses may be byte-wise.
// - random port ignores sequential inputs.
// - retention needs select high at clock.
// - clocked read advances pointer and flags.
// - host never asserts both selects together.
// - flag drops when pointer meets end.
`timescale 1ns/100ps
module brrp_device (
  input wire logic clock,
  input wire logic rstn,
  brrp_if.device rp,
  input wire logic seq_port_select_n,
  input wire logic pointer_advance_enable_n,
  input wire logic seq_read_write,
  input wire logic seq_output_enable_n,
  input wire logic [15:0] seq_data_in,
  output logic [15:0] seq_data_out,
  output logic seq_data_oe,
  output logic buffer_one_end_flag_n,
  output logic buffer_two_end_flag_n,
  output logic powered_down,
  output logic retention
);
  logic [15:0] mem [0:8191];
  logic [12:0] start_one, end_one, start_two, end_two, flow_mode;
  logic [12:0] pointer;
  logic read_active;
  logic [12:0] cmd_rd;
  logic [1:0] lane_en;
  logic array_rd, array_wr, cmd_wr, cmd_rd_en, clear_one, clear_two;
  logic [15:0] next_data, next_oe;
  logic [1:0] ps_sync, cs_sync, rw_sync, oe_sync, lb_sync, ub_sync;
  logic [12:0] addr_meta, addr_q;
  logic [15:0] bus_meta, bus_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; every decision reads the second stage only.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ps_sync <= 2'h3;
      cs_sync <= 2'h3;
      rw_sync <= 2'h3;
      oe_sync <= 2'h3;
      lb_sync <= 2'h3;
      ub_sync <= 2'h3;
      addr_meta <= 13'h0000;
      addr_q <= 13'h0000;
      bus_meta <= 16'h0000;
      bus_q <= 16'h0000;
    end else begin
      ps_sync <= {ps_sync[0], rp.port_select_n};
      cs_sync <= {cs_sync[0], rp.cmd_select_n};
      rw_sync <= {rw_sync[0], rp.read_write};
      oe_sync <= {oe_sync[0], rp.output_enable_n};
      lb_sync <= {lb_sync[0], rp.low_byte_enable_n};
      ub_sync <= {ub_sync[0], rp.high_byte_enable_n};
      // Address and data pass the same two stages as the strobes, so all of them reach the decode together.
      addr_meta <= rp.addr;
      addr_q <= addr_meta;
      bus_meta <= rp.data_bus;
      bus_q <= bus_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode of the random port; no sequential input enters here.
  // Lane enables are active high here; bit zero is the low byte.
  assign lane_en = {!ub_sync[1], !lb_sync[1]};
  assign array_rd = !ps_sync[1] && cs_sync[1] && rw_sync[1] && !oe_sync[1];
  assign array_wr = !ps_sync[1] && cs_sync[1] && !rw_sync[1] && oe_sync[1];
  // The host must not assert both selects; that case is treated as no access.
  assign cmd_wr = ps_sync[1] && !cs_sync[1] && !rw_sync[1] && oe_sync[1];
  assign cmd_rd_en = ps_sync[1] && !cs_sync[1] && rw_sync[1] && !oe_sync[1];
  // A zero written to bit zero or one at the flag offset clears that flag.
  assign clear_one = cmd_wr && addr_q[2:0] == brrp_pkg::CMD_FLAGS && lane_en[0] && !bus_q[0];
  assign clear_two = cmd_wr && addr_q[2:0] == brrp_pkg::CMD_FLAGS && lane_en[0] && !bus_q[1];

  always_comb begin
    unique case (addr_q[2:0])
      brrp_pkg::CMD_START1: cmd_rd = start_one;
      brrp_pkg::CMD_END1: cmd_rd = end_one;
      brrp_pkg::CMD_START2: cmd_rd = start_two;
      brrp_pkg::CMD_END2: cmd_rd = end_two;
      brrp_pkg::CMD_FLOW: cmd_rd = flow_mode;
      // Flag status reads back high for a flag that is set.
      brrp_pkg::CMD_FLAGS: cmd_rd = {11'h000, !buffer_two_end_flag_n, !buffer_one_end_flag_n};
      default: cmd_rd = 13'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array writes from both ports in one process; a random port write to the same word lands last and wins in its enabled bytes.
  always_ff @(posedge clock) begin
    // The sequential port writes at the pointer while selected in write direction.
    if (!seq_port_select_n && !seq_read_write) begin
      mem[pointer] <= seq_data_in;
    end
    for (int b = 0; b < 2; b++) begin
      if (array_wr && lane_en[b]) begin
        mem[addr_q][b*8 +: 8] <= bus_q[b*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command registers, written per byte lane on the low twelve lines.
  function automatic logic [12:0] merge_cmd(input logic [12:0] old, input logic [15:0] d,
                                             input logic [1:0] en);
    logic [12:0] r;
    r = old;
    if (en[0]) begin
      r[7:0] = d[7:0];
    end
    if (en[1]) begin
      r[11:8] = d[11:8];
    end
    return r;
  endfunction : merge_cmd

  // Bit twelve of a stored address changes only at reset; command writes reach lines zero to eleven.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      start_one <= brrp_pkg::RST_START1;
      end_one <= brrp_pkg::RST_END1;
      start_two <= brrp_pkg::RST_START2;
      end_two <= brrp_pkg::RST_END2;
      flow_mode <= brrp_pkg::RST_FLOW;
    end else if (cmd_wr) begin
      unique case (addr_q[2:0])
        brrp_pkg::CMD_START1: start_one <= merge_cmd(start_one, bus_q, lane_en);
        brrp_pkg::CMD_END1: end_one <= merge_cmd(end_one, bus_q, lane_en);
        brrp_pkg::CMD_START2: start_two <= merge_cmd(start_two, bus_q, lane_en);
        brrp_pkg::CMD_END2: end_two <= merge_cmd(end_two, bus_q, lane_en);
        brrp_pkg::CMD_FLOW: flow_mode <= merge_cmd(flow_mode, bus_q, lane_en);
        default: flow_mode <= flow_mode;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Random port output drivers.
  always_comb begin
    next_data = 16'h0000;
    next_oe = 16'h0000;
    if (array_rd) begin
      next_data = mem[addr_q];
      next_oe = {{8{lane_en[1]}}, {8{lane_en[0]}}};
    end else if (cmd_rd_en) begin
      next_data = {3'h0, cmd_rd};
      // Lines thirteen to fifteen stay undriven in a command read.
      next_oe = {3'h0, {5{lane_en[1]}}, {8{lane_en[0]}}};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rp.dev_data <= 16'h0000;
      rp.dev_data_oe <= 16'h0000;
      powered_down <= 1'b1;
    end else begin
      rp.dev_data <= next_data;
      rp.dev_data_oe <= next_oe;
      // One select low keeps the port awake even when no transfer is made.
      powered_down <= ps_sync[1] && cs_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequential side: pointer, flags and read data.
  brrp_seq_flags u_seq (
    .clock(clock),
    .rstn(rstn),
    .seq_port_select_n(seq_port_select_n),
    .pointer_advance_enable_n(pointer_advance_enable_n),
    .seq_read_write(seq_read_write),
    .seq_output_enable_n(seq_output_enable_n),
    .end_one(end_one),
    .end_two(end_two),
    .clear_one(clear_one),
    .clear_two(clear_two),
    .pointer(pointer),
    .buffer_one_end_flag_n(buffer_one_end_flag_n),
    .buffer_two_end_flag_n(buffer_two_end_flag_n),
    .retention(retention),
    .read_active(read_active)
  );

  // Read data follows the pointer on every edge; the enable tells when it is valid.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seq_data_out <= 16'h0000;
      seq_data_oe <= 1'b0;
    end else begin
      seq_data_out <= mem[pointer];
      seq_data_oe <= read_active;
    end
  end
endmodule : brrp_device

// ==== core/brrp_host.sv ====
// Host end: turns user requests into random port cycles.
`timescale 1ns/100ps
module brrp_host (
  input wire logic clock,
  input wire logic rstn,
  brrp_if.host rp,
  input wire logic req,
  input wire logic req_cmd,
  input wire logic req_write,
  input wire logic [1:0] req_lanes,
  input wire logic [12:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [15:0] rdata
);
  brrp_pkg::brrp_host_e state;
  logic [3:0] hold;
  logic [15:0] rd_sync1, rd_sync2;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_sync1 <= 16'h0000;
      rd_sync2 <= 16'h0000;
    end else begin
      rd_sync1 <= rp.data_bus;
      rd_sync2 <= rd_sync1;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= brrp_pkg::BRRP_IDLE;
      hold <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      rp.port_select_n <= 1'b1;
      rp.cmd_select_n <= 1'b1;
      rp.read_write <= 1'b1;
      rp.output_enable_n <= 1'b1;
      rp.low_byte_enable_n <= 1'b1;
      rp.high_byte_enable_n <= 1'b1;
      rp.addr <= 13'h0000;
      rp.host_data <= 16'h0000;
      rp.host_data_oe <= 16'h0000;
    end else begin
      done <= 1'b0;
      unique case (state)
        brrp_pkg::BRRP_IDLE: begin
          if (req) begin
            state <= brrp_pkg::BRRP_DRIVE;
            busy <= 1'b1;
            hold <= 4'h0;
            rp.port_select_n <= req_cmd;
            rp.cmd_select_n <= !req_cmd;
            rp.read_write <= !req_write;
            rp.output_enable_n <= req_write;
            rp.low_byte_enable_n <= !req_lanes[0];
            rp.high_byte_enable_n <= !req_lanes[1];
            rp.addr <= req_addr;
            rp.host_data <= req_wdata;
            rp.host_data_oe <= req_write ? {{8{req_lanes[1]}}, {8{req_lanes[0]}}} : 16'h0000;
          end
        end
        brrp_pkg::BRRP_DRIVE: begin
          hold <= hold + 4'h1;
          if (hold == 4'(brrp_pkg::HOST_HOLD_CYC + 4)) begin
            rdata <= rd_sync2;
            state <= brrp_pkg::BRRP_HOLD;
            rp.port_select_n <= 1'b1;
            rp.cmd_select_n <= 1'b1;
            rp.read_write <= 1'b1;
            rp.output_enable_n <= 1'b1;
            rp.low_byte_enable_n <= 1'b1;
            rp.high_byte_enable_n <= 1'b1;
            rp.host_data_oe <= 16'h0000;
          end
        end
        brrp_pkg::BRRP_HOLD: begin
          hold <= hold + 4'h1;
          if (hold == 4'(2 * brrp_pkg::HOST_HOLD_CYC + 8)) begin
            state <= brrp_pkg::BRRP_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: state <= brrp_pkg::BRRP_IDLE;
      endcase
    end
  end
endmodule : brrp_host

// ==== testbench/brrp_sva.sv ====
// Checker for the random port pin decode seen on the interface.
`timescale 1ns/100ps
module brrp_sva (
  input wire logic clock,
  input wire logic rstn,
  input wire logic port_select_n,
  input wire logic cmd_select_n,
  input wire logic read_write,
  input wire logic output_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic high_byte_enable_n,
  input wire logic [15:0] dev_data_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // A decode is taken as settled once the pins have held for five edges.
  wire arr_rd = !port_select_n && cmd_select_n && read_write && !output_enable_n;
  wire arr_wr = !port_select_n && cmd_select_n && !read_write && output_enable_n;
  wire cmd_rd = port_select_n && !cmd_select_n && read_write && !output_enable_n;
  wire cmd_wr = port_select_n && !cmd_select_n && !read_write && output_enable_n;
  wire [7:0] lo = {8{!low_byte_enable_n}};
  wire [7:0] hi = {8{!high_byte_enable_n}};
  ////////////////////////////////////////
  property p_read_lanes;
    arr_rd [*5] |-> dev_data_oe == {hi, lo};
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("read lanes");
  property p_write_quiet;
    arr_wr [*5] |-> dev_data_oe == 16'h0000;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("drive in write");
  property p_idle_float;
    (port_select_n && cmd_select_n) [*5] |-> dev_data_oe == 16'h0000;
  endproperty
  a_idle_float: assert property (p_idle_float) else $error("drive when idle");
  property p_oe_release;
    $rose(output_enable_n) |-> ##[1:5] dev_data_oe == 16'h0000;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("no release");
  property p_no_lanes;
    (!port_select_n && low_byte_enable_n && high_byte_enable_n) [*5] |-> dev_data_oe == 16'h0000;
  endproperty
  a_no_lanes: assert property (p_no_lanes) else $error("drive without lanes");
  property p_cmd_write;
    cmd_wr [*5] |-> dev_data_oe == 16'h0000;
  endproperty
  a_cmd_write: assert property (p_cmd_write) else $error("drive in command write");
  property p_cmd_width;
    (cmd_rd && !low_byte_enable_n && !high_byte_enable_n) [*5] |-> dev_data_oe == 16'h1FFF;
  endproperty
  a_cmd_width: assert property (p_cmd_width) else $error("command read width");
  property p_cmd_bytes;
    cmd_rd [*5] |-> dev_data_oe == {3'h0, hi[4:0], lo};
  endproperty
  a_cmd_bytes: assert property (p_cmd_bytes) else $error("command read lanes");
  property p_one_select;
    port_select_n || cmd_select_n;
  endproperty
  a_one_select: assert property (p_one_select) else $error("both selects low");
  c_low_read: cover property (arr_rd && high_byte_enable_n && !low_byte_enable_n);
  c_cmd_read: cover property (cmd_rd);
  c_cmd_write: cover property (cmd_wr);
endmodule : brrp_sva

// ==== testbench/tb.sv ====
// Self-checking testbench joining the host and device ends of the random port.
`timescale 1ns/100ps
module tb;
  logic clock, rstn, req, req_cmd, req_write, done, awake;
  logic [1:0] req_lanes;
  logic [12:0] req_addr;
  logic [15:0] req_wdata, rdata;
  logic seq_port_select_n, pointer_advance_enable_n, seq_read_write, seq_output_enable_n;
  logic buffer_one_end_flag_n, buffer_two_end_flag_n, powered_down, retention;
  logic busy, seq_data_oe;
  logic [15:0] seq_data_out;
  int mismatches = 0;
  int total_checks = 0;
  brrp_if brrp_if_inst ();
  brrp_host brrp_host_inst (.clock, .rstn, .rp(brrp_if_inst.host), .req, .req_cmd, .req_write, .req_lanes,
    .req_addr, .req_wdata, .busy, .done, .rdata);
  brrp_device brrp_device_inst (.clock, .rstn, .rp(brrp_if_inst.device), .seq_port_select_n,
    .pointer_advance_enable_n, .seq_read_write, .seq_output_enable_n, .seq_data_in(16'h0000), .seq_data_out,
    .seq_data_oe, .buffer_one_end_flag_n, .buffer_two_end_flag_n, .powered_down, .retention);
  brrp_sva brrp_sva_inst (.clock, .rstn, .port_select_n(brrp_if_inst.port_select_n),
    .cmd_select_n(brrp_if_inst.cmd_select_n), .read_write(brrp_if_inst.read_write),
    .output_enable_n(brrp_if_inst.output_enable_n), .low_byte_enable_n(brrp_if_inst.low_byte_enable_n),
    .high_byte_enable_n(brrp_if_inst.high_byte_enable_n), .dev_data_oe(brrp_if_inst.dev_data_oe));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask : check
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Runs one host request to its done pulse; awake notes any powered-up cycle on the way.
  task automatic xfer(input logic cmd, input logic wr, input logic [1:0] lanes, input logic [12:0] a,
    input logic [15:0] d);
    int n = 0;
    {req, req_cmd, req_write, req_lanes, req_addr, req_wdata} = {1'b1, cmd, wr, lanes, a, d};
    @(posedge clock);
    #1 req = 1'b0;
    check({15'h0000, busy}, 16'h0001);
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
      if (powered_down === 1'b0) awake = 1'b1;
    end
    if (n == 40) begin
      check(16'h0000, 16'h0001);
      end_of_test();
    end
  endtask : xfer
  task automatic rd(input logic cmd, input logic [1:0] lanes, input logic [12:0] a, input logic [15:0] exp);
    xfer(cmd, 1'b0, lanes, a, 16'h0000);
    check(rdata, exp);
  endtask : rd
  ////////////////////////////////////////
  task automatic t_array();
    xfer(1'b0, 1'b1, 2'b11, 13'h0123, 16'hA55A);
    rd(1'b0, 2'b11, 13'h0123, 16'hA55A);
    xfer(1'b0, 1'b1, 2'b01, 13'h0123, 16'h1234);
    rd(1'b0, 2'b11, 13'h0123, 16'hA534);
    rd(1'b0, 2'b01, 13'h0123, 16'hFF34);
    rd(1'b0, 2'b10, 13'h0123, 16'hA5FF);
    awake = 1'b0;
    xfer(1'b0, 1'b1, 2'b00, 13'h0123, 16'h0000);
    check({15'h0000, awake}, 16'h0001);
    rd(1'b0, 2'b11, 13'h0123, 16'hA534);
    xfer(1'b0, 1'b1, 2'b11, 13'h1FFF, 16'h0F0F);
    rd(1'b0, 2'b11, 13'h1FFF, 16'h0F0F);
    check({15'h0000, powered_down}, 16'h0001);
  endtask : t_array
  task automatic t_cmd();
    logic [15:0] rst_val [5];
    rst_val = '{{3'h7, brrp_pkg::RST_START1}, {3'h7, brrp_pkg::RST_END1}, {3'h7, brrp_pkg::RST_START2},
      {3'h7, brrp_pkg::RST_END2}, {3'h7, brrp_pkg::RST_FLOW}};
    for (int i = 0; i < 5; i++) begin
      rd(1'b1, 2'b11, i[12:0], rst_val[i]);
    end
    // Upper address bits play no part in a command access.
    xfer(1'b1, 1'b1, 2'b11, 13'h1FF9, 16'hFABC);
    rd(1'b1, 2'b11, 13'h0001, 16'hEABC);
    xfer(1'b1, 1'b1, 2'b10, 13'h0002, 16'h0500);
    rd(1'b1, 2'b11, 13'h0002, 16'hF500);
    rd(1'b1, 2'b01, 13'h0002, 16'hFF00);
  endtask : t_cmd
  task automatic t_seq();
    xfer(1'b1, 1'b1, 2'b11, 13'h0001, 16'h0005);
    // The next read spans fourteen edges of pointer advance, so the pointer then rests on word 0x000E.
    xfer(1'b0, 1'b1, 2'b11, 13'h000E, 16'h3CC3);
    {seq_port_select_n, pointer_advance_enable_n, seq_read_write, seq_output_enable_n} = 4'b0010;
    rd(1'b0, 2'b11, 13'h0123, 16'hA534);
    check({15'h0000, seq_data_oe}, 16'h0001);
    check({14'h0000, buffer_two_end_flag_n, buffer_one_end_flag_n}, 16'h0002);
    check({15'h0000, retention}, 16'h0000);
    {seq_port_select_n, pointer_advance_enable_n} = 2'b11;
    repeat (2) @(posedge clock);
    #1 check({15'h0000, retention}, 16'h0001);
    check(seq_data_out, 16'h3CC3);
    check({15'h0000, seq_data_oe}, 16'h0000);
    xfer(1'b1, 1'b0, 2'b11, 13'h0005, 16'h0000);
    check({14'h0000, rdata[1:0]}, 16'h0001);
    xfer(1'b1, 1'b1, 2'b01, 13'h0005, 16'h0000);
    check({14'h0000, buffer_two_end_flag_n, buffer_one_end_flag_n}, 16'h0003);
  endtask : t_seq
  ////////////////////////////////////////
  initial begin
    {rstn, req, req_cmd, req_write, req_lanes, req_addr, req_wdata, awake} = '0;
    {seq_port_select_n, pointer_advance_enable_n, seq_read_write, seq_output_enable_n} = 4'b1111;
    repeat (12) @(posedge clock);
    #1 rstn = 1'b1;
    t_array();
    t_cmd();
    t_seq();
    end_of_test();
  end
endmodule : tb
